// File: verilog/dcpec_core_counter.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module dcpec_core_counter
	import dcpec_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// This core
	input  wire logic        coreHalted,
	input  wire logic        coreSnooped,
	input  wire logic        firstLevelPrefetchReq,
	input  wire logic        dataCacheShareSnoop,
	input  wire logic        busTxnOutstanding,
	input  wire logic        busDrdyOwn,
	input  wire logic        l2RefuseOwn,
	input  wire logic        l2IdleOwn,
	input  wire logic        busSnoopRespOwn,
	// Other core and shared resources
	input  wire logic        otherCoreHalted,
	input  wire logic        busDrdyAny,
	input  wire logic        l2RefuseAny,
	input  wire logic        l2IdleAny,
	input  wire logic        busSnoopRespAny,
	// Status
	output logic             coreActive,
	output logic             busClkTick
);
	// =========================================
	// Register state
	logic [31:0]        evsel;
	logic [31:0]        next_evsel;
	logic [COUNT_W-1:0] count;
	logic               cntClear;
	logic               cntInc;
	logic [31:0]        next_prdata;
	logic [2:0]         divCnt;
	logic [2:0]         next_divCnt;
	logic               next_busClkTick;
	logic               countEn;
	logic [7:0]         evCode;
	logic [7:0]         umask;
	logic               allCores;
	logic               wrAccess;
	logic               rdAccess;
	logic               mapped;

	assign evCode   = evsel[EVSEL_CODE_LSB +: 8];
	assign umask    = evsel[EVSEL_UMASK_LSB +: 8];
	assign allCores = (evsel[EVSEL_CSPEC_LSB +: 2] == CSPEC_ALL);
	assign countEn  = evsel[EVSEL_EN_BIT];
	assign coreActive = !coreHalted || coreSnooped;

	// =========================================
	// Bus clock enable from core clock divider
	always_comb begin
		next_divCnt     = divCnt + 3'h1;
		next_busClkTick = 1'b0;
		if (divCnt == 3'(BUS_RATIO - 1)) begin
			next_divCnt     = 3'h0;
			next_busClkTick = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			divCnt     <= 3'h0;
			busClkTick <= 1'b0;
		end else begin
			divCnt     <= next_divCnt;
			busClkTick <= next_busClkTick;
		end
	end

	// =========================================
	// Event selection
	always_comb begin
		cntInc = 1'b0;
		case (evCode)
			EV_UNHALTED: begin
				// Snoop does not wake these counts
				if (!coreHalted) begin
					case (umask[5:0])
						UM_CORE:   cntInc = 1'b1;
						UM_REF:    cntInc = busClkTick;
						UM_SERIAL: cntInc = busClkTick
							&& otherCoreHalted;
						default:   cntInc = 1'b0;
					endcase
				end
			end
			EV_L2_REFUSE:
				cntInc = allCores ? l2RefuseAny : l2RefuseOwn;
			EV_L2_IDLE:
				cntInc = allCores ? l2IdleAny : l2IdleOwn;
			EV_L1_PREF:
				cntInc = firstLevelPrefetchReq;
			EV_DC_SNOOP:
				cntInc = (umask[5:0] == UM_SHARE)
					&& dataCacheShareSnoop;
			EV_BUS_IDLE:
				cntInc = busClkTick && !busTxnOutstanding;
			EV_BUS_SNOOPS:
				cntInc = allCores ? busSnoopRespAny
					: busSnoopRespOwn;
			EV_BUS_DRDY:
				cntInc = (umask == UM_ALL_AGENTS || allCores)
					? busDrdyAny : busDrdyOwn;
			default:
				cntInc = 1'b0;
		endcase
		// Inactive core freezes every event
		if (!coreActive || !countEn) begin
			cntInc = 1'b0;
		end
	end

	// =========================================
	// APB slave, zero wait states
	assign pready   = 1'b1;
	assign wrAccess = psel && penable && pwrite;
	assign rdAccess = psel && !penable && !pwrite;
	assign mapped   = (paddr == ADDR_EVSEL) || (paddr == ADDR_COUNT_LO)
		|| (paddr == ADDR_COUNT_HI) || (paddr == ADDR_STATUS);
	assign pslverr  = psel && penable && !mapped;
	assign cntClear = wrAccess && (paddr == ADDR_COUNT_LO);

	always_comb begin
		next_evsel = evsel;
		if (wrAccess && paddr == ADDR_EVSEL) begin
			next_evsel = pwdata & EVSEL_WMASK;
		end
	end

	// Read data captured in setup so it stands through access
	always_comb begin
		next_prdata = prdata;
		if (rdAccess) begin
			case (paddr)
				ADDR_EVSEL:    next_prdata = evsel;
				ADDR_COUNT_LO: next_prdata = count[31:0];
				ADDR_COUNT_HI: next_prdata = {24'h0, count[39:32]};
				ADDR_STATUS:   next_prdata = {29'h0, otherCoreHalted,
					coreHalted, coreActive};
				default:       next_prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			evsel  <= EVSEL_RESET;
			prdata <= 32'h0;
		end else begin
			evsel  <= next_evsel;
			prdata <= next_prdata;
		end
	end

	// =========================================
	// Event counter
	dcpec_counter uCounter (
		.clk   (clk),
		.reset (reset),
		.clear (cntClear),
		.inc   (cntInc),
		.count (count)
	);

	// =========================================
	// Checks: activity gating
	a_inactive_no_count: assert property (
		@(posedge clk) disable iff (reset)
		(coreHalted && !coreSnooped && !cntClear)
		|=> $stable(count))
		else $error("counter moved while core inactive");
	a_inactive_gate: assert property (
		@(posedge clk) disable iff (reset)
		!coreActive
		|-> !cntInc)
		else $error("increment while core inactive");
	a_active_def: assert property (
		@(posedge clk) disable iff (reset)
		coreActive ==
		(!coreHalted || coreSnooped))
		else $error("core active condition wrong");
	a_snoop_wakes: assert property (
		@(posedge clk) disable iff (reset)
		(coreHalted && coreSnooped && evCode == EV_L1_PREF)
		|-> cntInc == (countEn && firstLevelPrefetchReq))
		else $error("snooped halted core not counting");
	a_halt_unhalted: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_UNHALTED && coreHalted && !cntClear)
		|=> $stable(count))
		else $error("unhalted count moved on halted core");
	a_snoop_no_unhalted: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_UNHALTED && coreHalted && coreSnooped)
		|-> !cntInc)
		else $error("snoop advanced an unhalted count");

	// =========================================
	// Checks: cycle counting
	a_core_cycles: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_UNHALTED && umask == 8'h00
		&& !coreHalted && !cntClear) |=> count == $past(count) + 1)
		else $error("core cycle count missed");
	a_core_every: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_UNHALTED && umask[5:0] == UM_CORE)
		|-> cntInc == !coreHalted)
		else $error("core cycle not counted");
	a_ref_rate: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_UNHALTED && umask == 8'h01 && !busClkTick)
		|-> !cntInc)
		else $error("reference count off bus tick");
	a_ref_count: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_UNHALTED && umask[5:0] == UM_REF)
		|-> cntInc == (busClkTick && !coreHalted))
		else $error("reference cycle not counted");
	a_tick_period: assert property (
		@(posedge clk) disable iff (reset)
		busClkTick
		|=> !busClkTick [*3] ##1 busClkTick)
		else $error("bus tick period wrong");
	a_serial_other: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_UNHALTED && umask == 8'h02 && !otherCoreHalted)
		|-> !cntInc)
		else $error("serial count with other core running");
	a_serial_count: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_UNHALTED && umask[5:0] == UM_SERIAL)
		|-> cntInc == (busClkTick && otherCoreHalted && !coreHalted))
		else $error("serial cycle not counted");

	// =========================================
	// Checks: shared resources and bus
	a_refuse_all: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_L2_REFUSE && allCores && coreActive)
		|-> cntInc == l2RefuseAny)
		else $error("all-core refusal not counted");
	a_idle_all: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_L2_IDLE && allCores && coreActive)
		|-> cntInc == l2IdleAny)
		else $error("all-core idle not counted");
	a_resp_all: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_BUS_SNOOPS && allCores && coreActive)
		|-> cntInc == busSnoopRespAny)
		else $error("all-core snoop response not counted");
	a_drdy_agents: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_BUS_DRDY && umask == UM_ALL_AGENTS)
		|-> cntInc == (coreActive && busDrdyAny))
		else $error("all-agent data-ready not counted");
	a_drdy_own: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_BUS_DRDY && umask != UM_ALL_AGENTS && !allCores)
		|-> cntInc == (countEn && coreActive && busDrdyOwn))
		else $error("own data-ready count wrong");
	a_refuse_own: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_L2_REFUSE && !allCores)
		|-> cntInc == (countEn && coreActive && l2RefuseOwn))
		else $error("own refusal count wrong");
	a_idle_own: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_L2_IDLE && !allCores)
		|-> cntInc == (countEn && coreActive && l2IdleOwn))
		else $error("own cache idle count wrong");
	a_pref_count: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_L1_PREF && coreActive)
		|-> cntInc == firstLevelPrefetchReq)
		else $error("prefetch request not counted");
	a_share_snoop: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_DC_SNOOP && umask[5:0] == UM_SHARE)
		|-> cntInc == (coreActive && dataCacheShareSnoop))
		else $error("share snoop not counted");
	a_share_mask: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_DC_SNOOP && umask[5:0] != UM_SHARE)
		|-> !cntInc)
		else $error("share snoop counted with wrong mask");
	a_bus_idle: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_BUS_IDLE && busTxnOutstanding)
		|-> !cntInc)
		else $error("bus idle counted while outstanding");
	a_idle_tick: assert property (
		@(posedge clk) disable iff (reset)
		(countEn && evCode == EV_BUS_IDLE && coreActive && busClkTick)
		|-> cntInc == !busTxnOutstanding)
		else $error("idle bus cycle not counted");
	a_resp_own: assert property (
		@(posedge clk) disable iff (reset)
		(evCode == EV_BUS_SNOOPS && !allCores)
		|-> cntInc == (countEn && coreActive && busSnoopRespOwn))
		else $error("own snoop response count wrong");

	// =========================================
	// Checks: counter and select register
	a_count_step: assert property (
		@(posedge clk) disable iff (reset)
		(cntInc && !cntClear)
		|=> count == $past(count) + 1)
		else $error("counter did not step by one");
	a_count_hold: assert property (
		@(posedge clk) disable iff (reset)
		(!cntInc && !cntClear)
		|=> $stable(count))
		else $error("counter moved without an event");
	a_count_clear: assert property (
		@(posedge clk) disable iff (reset)
		cntClear
		|=> count == '0)
		else $error("counter not cleared");
	a_disabled_still: assert property (
		@(posedge clk) disable iff (reset)
		!countEn
		|-> !cntInc)
		else $error("increment while counting disabled");
	a_evsel_write: assert property (
		@(posedge clk) disable iff (reset)
		(wrAccess && paddr == ADDR_EVSEL)
		|=> evsel == ($past(pwdata) & EVSEL_WMASK))
		else $error("event select write lost");
endmodule

// File: shared/dcpec_pkg.sv
package dcpec_pkg;
	// =========================================
	// Register map (APB byte addresses)
	localparam logic [11:0] ADDR_EVSEL    = 12'h000;
	localparam logic [11:0] ADDR_COUNT_LO = 12'h004;
	localparam logic [11:0] ADDR_COUNT_HI = 12'h008;
	localparam logic [11:0] ADDR_STATUS   = 12'h00C;
	// =========================================
	// Event-select fields
	localparam int EVSEL_CODE_LSB  = 0;
	localparam int EVSEL_UMASK_LSB = 8;
	localparam int EVSEL_CSPEC_LSB = 14;
	localparam int EVSEL_EN_BIT    = 22;
	localparam logic [31:0] EVSEL_RESET = 32'h0000_0000;
	localparam logic [31:0] EVSEL_WMASK = 32'h0040_FFFF;
	// =========================================
	// Event codes and unit masks
	localparam logic [7:0] EV_L2_REFUSE  = 8'h30;
	localparam logic [7:0] EV_L2_IDLE    = 8'h32;
	localparam logic [7:0] EV_UNHALTED   = 8'h3C;
	localparam logic [7:0] EV_L1_PREF    = 8'h4F;
	localparam logic [7:0] EV_BUS_SNOOPS = 8'h77;
	localparam logic [7:0] EV_DC_SNOOP   = 8'h78;
	localparam logic [7:0] EV_BUS_IDLE   = 8'h7D;
	localparam logic [7:0] EV_BUS_DRDY   = 8'h62;
	localparam logic [5:0] UM_CORE       = 6'h00;
	localparam logic [5:0] UM_REF        = 6'h01;
	localparam logic [5:0] UM_SERIAL     = 6'h02;
	localparam logic [5:0] UM_SHARE      = 6'h01;
	localparam logic [7:0] UM_ALL_AGENTS = 8'h20;
	localparam logic [1:0] CSPEC_ALL     = 2'b11;
	// =========================================
	// Clocking: bus clock is core clock divided
	localparam int BUS_RATIO = 4;
	localparam int COUNT_W   = 40;
	typedef enum logic [1:0] {DCPEC_IDLE, DCPEC_ACCESS} dcpec_apb_t;
endpackage

// File: verilog/dcpec_counter.sv
`timescale 1ns/1ns
module dcpec_counter
	import dcpec_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// Control
	input  wire logic               clear,
	input  wire logic               inc,
	// Value
	output logic [COUNT_W-1:0]      count
);
	logic [COUNT_W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (inc) begin
			next_count = count + {{(COUNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule

// File: test/dcpec_far_model.sv
`timescale 1ns/1ns
// =========================================
// Other core, shared cache and bus agents
module dcpec_far_model (
	// Clock and control
	input  wire logic clk,
	input  wire logic run,
	// Shared-resource activity
	output logic      otherCoreHalted,
	output logic      busDrdyAny,
	output logic      l2RefuseAny,
	output logic      l2IdleAny,
	output logic      busSnoopRespAny
);
	logic [31:0] r;
	initial r = 32'h0;
	// Quiet outside runs, so set-up cycles add nothing
	always @(posedge clk) begin
		r = run ? $urandom : 32'h0;
		otherCoreHalted <= r[0];
		busDrdyAny      <= r[1];
		l2RefuseAny     <= r[2];
		l2IdleAny       <= r[3];
		busSnoopRespAny <= r[4];
	end
endmodule

// File: test/dcpec_core_counter_test.sv
`timescale 1ns/1ns
`define CHK(n,e,s) begin samplesChecked++; if ((s) !== (e)) begin \
	failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module dcpec_core_counter_test import dcpec_pkg::*;;
	// =========================================
	// Signals
	logic        clk = 1'h0, reset = 1'h1, run = 1'h0, tk, err;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, sel = 32'h0, rd, r;
	logic        coreHalted = 1'h1, coreSnooped = 1'h0;
	logic        firstLevelPrefetchReq = 1'h0, dataCacheShareSnoop = 1'h0;
	logic        busTxnOutstanding = 1'h1;
	logic        busDrdyOwn = 1'h0, l2RefuseOwn = 1'h0, l2IdleOwn = 1'h0;
	logic        busSnoopRespOwn = 1'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, coreActive, busClkTick, otherCoreHalted;
	logic        busDrdyAny, l2RefuseAny, l2IdleAny, busSnoopRespAny;
	logic [39:0] expCount = 40'h0, got;
	int          failures = 0, samplesChecked = 0, ph = 0;
	logic [15:0] tbl [16] = '{16'h0030, 16'hC030, 16'h0032, 16'hC032,
		16'h003C, 16'h013C, 16'h023C, 16'h004F, 16'h0178, 16'h0078,
		16'h007D, 16'h0077, 16'hC077, 16'h0062, 16'h2062, 16'hC062};

	always #2 clk = ~clk;
	dcpec_core_counter i_dut (.*);
	dcpec_far_model i_far (.*);

	// =========================================
	// Own-core stimulus; halted and busy outside runs
	always @(posedge clk) begin
		r = run ? $urandom : 32'h0;
		coreHalted <= run ? r[0] & r[1] : 1'h1;
		coreSnooped <= r[2] & r[3];
		busTxnOutstanding <= run ? r[4] : 1'h1;
		firstLevelPrefetchReq <= r[5];
		dataCacheShareSnoop <= r[6];
		busDrdyOwn <= r[7];
		l2RefuseOwn <= r[8];
		l2IdleOwn <= r[9];
		busSnoopRespOwn <= r[10];
	end

	// =========================================
	// Expected increment for the programmed selection
	function automatic logic hit();
		logic [7:0] u;
		logic a;
		logic all;
		u = sel[15:8];
		a = !coreHalted | coreSnooped;
		all = u[7:6] == CSPEC_ALL;
		if (!sel[EVSEL_EN_BIT]) return 1'h0;
		case (sel[7:0])
			EV_L2_REFUSE: return a & (all ? l2RefuseAny : l2RefuseOwn);
			EV_L2_IDLE: return a & (all ? l2IdleAny : l2IdleOwn);
			EV_UNHALTED: return !coreHalted & (u[5:0] == 6'h0 |
				tk & (u[5:0] == 6'h1 |
				u[5:0] == 6'h2 & otherCoreHalted));
			EV_L1_PREF: return a & firstLevelPrefetchReq;
			EV_DC_SNOOP: return a & u[5:0] == 6'h1 & dataCacheShareSnoop;
			EV_BUS_IDLE: return a & tk & !busTxnOutstanding;
			EV_BUS_SNOOPS: return a & (all ? busSnoopRespAny
				: busSnoopRespOwn);
			EV_BUS_DRDY: return a & (all | u == 8'h20 ? busDrdyAny
				: busDrdyOwn);
			default: return 1'h0;
		endcase
	endfunction

	// Own bus-clock phase, so the tick is not taken from the design
	always @(posedge clk) begin
		tk = ph != 0 && ph % BUS_RATIO == 0;
		if (!reset) begin
			`CHK("tick", tk, busClkTick)
			`CHK("active", !coreHalted | coreSnooped, coreActive)
			expCount += hit();
		end
		ph = reset ? 0 : ph + 1;
	end

	// =========================================
	// Bus master and verdict
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task automatic close_out();
		$display("failures %0d, checked %0d", failures, samplesChecked);
		if (failures == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#40000;
		failures++;
		close_out();
	end

	initial begin
		void'($urandom(32'h4359));
		repeat (6) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		apb(1'h0, ADDR_EVSEL, 32'h0);
		`CHK("evsel reset", EVSEL_RESET, rd)
		apb(1'h1, ADDR_EVSEL, 32'hFFFFFFFF);
		apb(1'h0, ADDR_EVSEL, 32'h0);
		`CHK("evsel mask", EVSEL_WMASK, rd)
		`CHK("mapped error", 1'h0, err)
		apb(1'h0, ADDR_STATUS, 32'h0);
		`CHK("status", 3'h2, rd[2:0])
		apb(1'h0, 12'h010, 32'h0);
		`CHK("unmapped", 33'h100000000, {err, rd})
		// Last pass repeats one code with counting off
		for (int i = 0; i < 17; i++) begin
			sel = {9'h0, i < 16, 6'h0, tbl[i % 16]};
			apb(1'h1, ADDR_COUNT_LO, 32'h0);
			apb(1'h1, ADDR_EVSEL, sel);
			expCount = 40'h0;
			run <= 1'h1;
			repeat (150) @(posedge clk);
			run <= 1'h0;
			repeat (2) @(posedge clk);
			// Count is not latched: stop it before reading halves
			apb(1'h1, ADDR_EVSEL, {16'h0, sel[15:0]});
			apb(1'h0, ADDR_COUNT_LO, 32'h0);
			got[31:0] = rd;
			apb(1'h0, ADDR_COUNT_HI, 32'h0);
			got[39:32] = rd[7:0];
			`CHK("count", expCount, got)
		end
		close_out();
	end
endmodule
